// ==== verilog/lcdd_driver.sv ====
// Four-digit static seven-segment display decoder and driver.
// Assumes link pins synchronous to mclk; srst is the only reset.
// Function
// - Held strobe decodes data into its digit
// - Strobes one..four map least to most significant
// - Data is four-bit positive binary, bit0 LSB
// - Code B: digits, dash, E, H, L, P, blank
// - Both selects low load data and address latches
// - Select rising edge stores glyph at latched address
// - Address 00..11 selects digit four..one
// - 28 segments driven statically from latches
// - Backplane is oscillator divided by 128
// - Free-running oscillator near 19 kHz
// - Timebase low disables backplane driver, follows pin
// - Slaves follow master backplane
// - Slave sensing ignores lows under one microsecond
// - Overdrive low phase under one microsecond
// - Over four devices use external backplane
// - External backplane at most about 150 Hz
`timescale 1ns/1ns
module lcdd_driver
    import lcdd_pkg::*;
#(
    parameter int OSC_HALF  = OSC_HALF_CYC,
    parameter int BP_DIV    = BP_DIVIDE,
    parameter int IGNORE_CY = SLAVE_IGNORE_CYC
) (
    input  wire logic          mclk,      // 20 MHz clock
    input  wire logic          srst,      // Synchronous reset, high
    input  wire logic          proc_mode, // 1: chip-select front end
    lcdd_if.dev                link,      // Pin side
    output logic [27:0]        seg,       // Segment lines, digit-major
    output logic               slave_mode // Backplane follows pin
);
    // ==========================================================
    // Front end
    logic [3:0] in_data;
    logic [1:0] in_addr;
    logic       sel_both_q;
    logic [6:0] glyph_reg [DIGITS];
    wire  [3:0] strobes = {link.digit_strobe_four,
                           link.digit_strobe_three,
                           link.digit_strobe_two,
                           link.digit_strobe_one};
    wire        sel_both = !link.select_low_a && !link.select_low_b;
    wire        sel_rise = sel_both_q && !sel_both;
    wire  [3:0] dec_src  = proc_mode ? in_data : link.data_in;
    wire  [1:0] addr_dig = 2'h3 - in_addr;
    logic [6:0] glyph;

    always_comb begin
        case (dec_src)
            4'h0: glyph = GLYPH_0;
            4'h1: glyph = GLYPH_1;
            4'h2: glyph = GLYPH_2;
            4'h3: glyph = GLYPH_3;
            4'h4: glyph = GLYPH_4;
            4'h5: glyph = GLYPH_5;
            4'h6: glyph = GLYPH_6;
            4'h7: glyph = GLYPH_7;
            4'h8: glyph = GLYPH_8;
            4'h9: glyph = GLYPH_9;
            4'hA: glyph = GLYPH_DASH;
            4'hB: glyph = GLYPH_E;
            4'hC: glyph = GLYPH_H;
            4'hD: glyph = GLYPH_L;
            4'hE: glyph = GLYPH_P;
            default: glyph = GLYPH_BLANK;
        endcase
    end

    // Input latches are transparent while both selects are low
    always_ff @(posedge mclk) begin
        if (srst) begin
            in_data    <= 4'h0;
            in_addr    <= 2'h0;
            sel_both_q <= 1'b0;
        end else begin
            sel_both_q <= sel_both && proc_mode;
            if (proc_mode && sel_both) begin
                in_data <= link.data_in;
                in_addr <= {link.digit_addr_high, link.digit_addr_low};
            end
        end
    end

    // ==========================================================
    // Output latches, one per digit
    genvar gi;
    generate
        for (gi = 0; gi < DIGITS; gi++) begin : g_dig
            wire wr_mux  = !proc_mode && strobes[gi];
            wire wr_proc = proc_mode && sel_rise &&
                           (addr_dig == 2'(gi));
            always_ff @(posedge mclk) begin
                if (srst)
                    glyph_reg[gi] <= SEG_RESET;
                else if (wr_mux || wr_proc)
                    glyph_reg[gi] <= glyph;
            end
        end
    endgenerate

    // ==========================================================
    // Oscillator, divider and slave sensing
    logic [15:0] osc_cnt;
    logic        osc_tick;
    logic [7:0]  div_cnt;
    logic [15:0] low_cnt;
    logic        bp_int;
    wire         osc_wrap = (osc_cnt == 16'(OSC_HALF - 1));
    wire         low_long = (low_cnt >= 16'(IGNORE_CY));
    // Half of BP_DIV oscillator cycles, each two half periods
    wire         div_wrap = (div_cnt == 8'(BP_DIV - 1));

    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_cnt  <= 16'h0000;
            div_cnt  <= 8'h00;
            bp_int   <= 1'b0;
            low_cnt  <= 16'h0000;
            slave_mode <= 1'b0;
        end else begin
            osc_cnt <= osc_wrap ? 16'h0000 : osc_cnt + 16'h0001;
            if (osc_wrap) begin
                div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
                if (div_wrap)
                    bp_int <= !bp_int;
            end
            // Short low glitches from an overdriving clock are ignored
            if (link.timebase_pin)
                low_cnt <= 16'h0000;
            else if (!low_long)
                low_cnt <= low_cnt + 16'h0001;
            slave_mode <= low_long;
        end
    end

    // One half oscillator period per div step: BP period = 128 osc
    logic bp_ref;
    always_ff @(posedge mclk) begin
        if (srst) begin
            link.bp_out <= 1'b0;
            link.bp_oe  <= 1'b0;
            bp_ref      <= 1'b0;
        end else begin
            link.bp_out <= bp_int;
            link.bp_oe  <= !low_long;
            bp_ref      <= low_long ? link.bp_in : bp_int;
        end
    end

    // Segment lines invert the backplane for lit segments
    generate
        for (gi = 0; gi < DIGITS; gi++) begin : g_seg
            always_ff @(posedge mclk) begin
                if (srst)
                    seg[gi*SEG_W +: SEG_W] <= SEG_RESET;
                else
                    seg[gi*SEG_W +: SEG_W] <=
                        glyph_reg[gi] ^ {SEG_W{bp_ref}};
            end
        end
    endgenerate
endmodule : lcdd_driver

// ==== verilog/lcdd_pkg.sv ====
// Constants shared by both ends of the four-digit segment display link.
// Assumes a single 20 MHz clock shared by both ends.
package lcdd_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int BP_DIVIDE       = 128;
    localparam int OSC_HZ          = 19_000;
    localparam int OSC_HALF_CYC    = CLK_HZ / (2 * OSC_HZ);
    localparam int SLAVE_IGNORE_NS = 1000;
    localparam int SLAVE_IGNORE_CYC =
        (SLAVE_IGNORE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int STROBE_MIN_NS   = 1000;
    localparam int STROBE_CYC      =
        (STROBE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SEL_MIN_NS      = 200;
    localparam int SEL_CYC         =
        (SEL_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int GAP_MIN_NS      = 2000;
    localparam int GAP_CYC         =
        (GAP_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ==========================================================
    // Data layout
    localparam int DIGITS    = 4;
    localparam int SEG_W     = 7;
    localparam int DATA_W    = 4;
    localparam int ADDR_W    = 2;

    // Segment order {g,f,e,d,c,b,a}
    localparam logic [6:0] GLYPH_0     = 7'h3F;
    localparam logic [6:0] GLYPH_1     = 7'h06;
    localparam logic [6:0] GLYPH_2     = 7'h5B;
    localparam logic [6:0] GLYPH_3     = 7'h4F;
    localparam logic [6:0] GLYPH_4     = 7'h66;
    localparam logic [6:0] GLYPH_5     = 7'h6D;
    localparam logic [6:0] GLYPH_6     = 7'h7D;
    localparam logic [6:0] GLYPH_7     = 7'h07;
    localparam logic [6:0] GLYPH_8     = 7'h7F;
    localparam logic [6:0] GLYPH_9     = 7'h6F;
    localparam logic [6:0] GLYPH_DASH  = 7'h40;
    localparam logic [6:0] GLYPH_E     = 7'h79;
    localparam logic [6:0] GLYPH_H     = 7'h76;
    localparam logic [6:0] GLYPH_L     = 7'h38;
    localparam logic [6:0] GLYPH_P     = 7'h73;
    localparam logic [6:0] GLYPH_BLANK = 7'h00;
    localparam logic [6:0] SEG_RESET   = 7'h00;

    typedef enum logic [3:0] {
        LCDD_IDLE   = 4'h1,
        LCDD_SETUP  = 4'h2,
        LCDD_ACTIVE = 4'h4,
        LCDD_GAP    = 4'h8
    } lcdd_host_e;
endpackage : lcdd_pkg

// ==== verilog/lcdd_if.sv ====
// Pin-level link between the display driver and its data source.
// The backplane wire is resolved from the two drive enables here.
`timescale 1ns/1ns
interface lcdd_if;
    logic [3:0] data_in;           // Binary data bits 3..0
    logic       digit_strobe_one;  // Strobe, least significant digit
    logic       digit_strobe_two;
    logic       digit_strobe_three;
    logic       digit_strobe_four; // Strobe, most significant digit
    logic       digit_addr_low;    // Shares pin with strobe one
    logic       digit_addr_high;   // Shares pin with strobe two
    logic       select_low_a;      // Active-low chip select a
    logic       select_low_b;      // Active-low chip select b
    logic       timebase_pin;      // Low selects slave mode
    logic       bp_in;             // Backplane level seen on the pin
    logic       bp_out;            // Backplane driven by master
    logic       bp_oe;             // Backplane drive enable
    logic       bp_ext;            // External backplane source level
    logic       bp_ext_oe;         // External source drive enable

    assign bp_in = bp_oe ? bp_out : (bp_ext_oe ? bp_ext : 1'b0);

    modport dev (
        input  data_in, digit_strobe_one, digit_strobe_two,
               digit_strobe_three, digit_strobe_four,
               digit_addr_low, digit_addr_high,
               select_low_a, select_low_b, timebase_pin, bp_in,
        output bp_out, bp_oe
    );
    modport src (
        output data_in, digit_strobe_one, digit_strobe_two,
               digit_strobe_three, digit_strobe_four,
               digit_addr_low, digit_addr_high,
               select_low_a, select_low_b, timebase_pin,
               bp_ext, bp_ext_oe,
        input  bp_in
    );
endinterface : lcdd_if

// ==== verilog/lcdd_source.sv ====
// Data source end: writes one digit per request using either strobes
// or chip selects; can also supply an external backplane.
// Assumes the driver samples the pins on the same mclk.
`timescale 1ns/1ns
module lcdd_source
    import lcdd_pkg::*;
(
    input  wire logic       mclk,      // 20 MHz clock
    input  wire logic       srst,      // Synchronous reset, high
    input  wire logic       proc_mode, // 1: chip-select protocol
    input  wire logic       req,       // Write request pulse
    input  wire logic [3:0] req_data,  // Value to show
    input  wire logic [1:0] req_digit, // 0 = least significant digit
    input  wire logic       slave_req, // Hold timebase low
    input  wire logic       ext_bp,    // External backplane level
    input  wire logic       ext_bp_en, // Drive external backplane while slave_req is high
    lcdd_if.src             link,      // Pin side
    output logic            busy       // Request in progress
);
    lcdd_host_e state;
    logic [15:0] cnt;
    logic [3:0]  dat;
    logic [1:0]  dig;
    wire  [1:0]  addr = 2'h3 - dig;    // Digit one is address 11
    wire         done = (cnt == 16'h0000);

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= LCDD_IDLE;
            cnt   <= 16'h0000;
            dat   <= 4'h0;
            dig   <= 2'h0;
            busy  <= 1'b0;
        end else begin
            if (!done)
                cnt <= cnt - 16'h0001;
            case (state)
                LCDD_IDLE: if (req) begin
                    dat   <= req_data;
                    dig   <= req_digit;
                    busy  <= 1'b1;
                    cnt   <= 16'(STROBE_CYC);
                    state <= LCDD_SETUP;
                end
                LCDD_SETUP: if (done) begin
                    cnt   <= 16'(proc_mode ? SEL_CYC : STROBE_CYC);
                    state <= LCDD_ACTIVE;
                end
                LCDD_ACTIVE: if (done) begin
                    cnt   <= 16'(GAP_CYC);
                    state <= LCDD_GAP;
                end
                LCDD_GAP: if (done) begin
                    busy  <= 1'b0;
                    state <= LCDD_IDLE;
                end
                default: state <= LCDD_IDLE;
            endcase
        end
    end

    wire act = (state == LCDD_ACTIVE);
    wire drv = (state == LCDD_SETUP) || act || (state == LCDD_GAP);

    always_ff @(posedge mclk) begin
        if (srst) begin
            link.data_in            <= 4'h0;
            link.digit_strobe_one   <= 1'b0;
            link.digit_strobe_two   <= 1'b0;
            link.digit_strobe_three <= 1'b0;
            link.digit_strobe_four  <= 1'b0;
            link.digit_addr_low     <= 1'b0;
            link.digit_addr_high    <= 1'b0;
            link.select_low_a       <= 1'b1;
            link.select_low_b       <= 1'b1;
            link.timebase_pin       <= 1'b1;
            link.bp_ext             <= 1'b0;
            link.bp_ext_oe          <= 1'b0;
        end else begin
            link.data_in <= drv ? dat : 4'h0;
            // Strobe and address share pins; mode picks the meaning
            link.digit_strobe_one   <= proc_mode ? (drv && addr[0])
                                               : (act && dig == 2'h0);
            link.digit_strobe_two   <= proc_mode ? (drv && addr[1])
                                               : (act && dig == 2'h1);
            link.digit_strobe_three <= proc_mode ? !(act)
                                               : (act && dig == 2'h2);
            link.digit_strobe_four  <= proc_mode ? !(act)
                                               : (act && dig == 2'h3);
            link.digit_addr_low     <= drv && addr[0];
            link.digit_addr_high    <= drv && addr[1];
            link.select_low_a       <= !(proc_mode && act);
            link.select_low_b       <= !(proc_mode && act);
            link.timebase_pin       <= !slave_req;
            link.bp_ext             <= ext_bp;
            link.bp_ext_oe          <= ext_bp_en && slave_req;
        end
    end
endmodule : lcdd_source

// ==== sim/lcdd_checker.sv ====
// Checker for the pins that join the source end to the driver end.
// Assumes one clock and a synchronous high reset for both ends.
`timescale 1ns/1ns
module lcdd_checker
    import lcdd_pkg::*;
#(
    parameter int HALF_CYC = 256  // Cycles per backplane half period
) (
    input wire logic       mclk,             // Clock
    input wire logic       srst,             // Reset, high
    input wire logic [3:0] data_in,          // Data bits
    input wire logic       digit_strobe_one, // First strobe
    input wire logic       digit_addr_low,   // Address bit 0
    input wire logic       digit_addr_high,  // Address bit 1
    input wire logic       select_low_a,     // Select a, low active
    input wire logic       select_low_b,     // Select b, low active
    input wire logic       timebase_pin,     // Low asks slave mode
    input wire logic       bp_out,           // Driven backplane
    input wire logic       bp_oe             // Backplane drive enable
);
    // ==========================================================
    // Backplane half-period counter
    logic [15:0] cnt;
    logic        bp_q;
    logic        seen;
    wire         both_sel = !select_low_a && !select_low_b;

    // The first segment after enable is partial, so it is not timed
    always_ff @(posedge mclk) begin
        bp_q <= bp_out;
        if (srst || !bp_oe) begin
            cnt  <= 16'h0000;
            seen <= 1'b0;
        end else if (bp_out != bp_q) begin
            cnt  <= 16'h0000;
            seen <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence s_short_low;
        bp_oe && $fell(timebase_pin) ##1 timebase_pin;
    endsequence
    sequence s_sel_held;
        both_sel && $past(both_sel);
    endsequence
    property p_sel_pair;
        $fell(select_low_a) |-> !select_low_b;
    endproperty
    property p_sel_width;
        $fell(select_low_a) |-> !select_low_a [*4];
    endproperty
    property p_bus_stable;
        s_sel_held |-> $stable({digit_addr_high, digit_addr_low, data_in});
    endproperty
    property p_stb_width;
        $rose(digit_strobe_one) |-> digit_strobe_one [*8];
    endproperty
    property p_bp_master;
        timebase_pin [*8] |-> bp_oe;
    endproperty
    property p_bp_slave;
        !timebase_pin [*8] |-> !bp_oe;
    endproperty
    property p_glitch;
        s_short_low |-> bp_oe [*4];
    endproperty
    property p_bp_half;
        bp_oe && seen && bp_out != bp_q |-> cnt == 16'(HALF_CYC - 1);
    endproperty
    property p_bp_max;
        bp_oe |-> cnt <= 16'(HALF_CYC);
    endproperty

    a_sel_pair: assert property (p_sel_pair)
        else $error("selects not taken low together");
    a_sel_width: assert property (p_sel_width)
        else $error("select low pulse too short");
    a_bus_stable: assert property (p_bus_stable)
        else $error("data or address moved while selected");
    a_stb_width: assert property (p_stb_width)
        else $error("digit strobe pulse too short");
    a_bp_master: assert property (p_bp_master)
        else $error("backplane not driven with timebase high");
    a_bp_slave: assert property (p_bp_slave)
        else $error("backplane still driven in slave mode");
    a_glitch: assert property (p_glitch)
        else $error("short timebase low disabled backplane");
    a_bp_half: assert property (p_bp_half)
        else $error("backplane half period wrong");
    a_bp_max: assert property (p_bp_max)
        else $error("backplane toggle missing");
endmodule : lcdd_checker

// ==== sim/four_digit_segment_lcd_driver_tb.sv ====
// Testbench: source end writes digits, driver end shows them.
// Assumes the pins join the two ends through one interface.
`timescale 1ns/1ns
module four_digit_segment_lcd_driver_tb
    import lcdd_pkg::*;
;
    localparam int OSC_H = 2;
    localparam int IGN   = 3;
    localparam int HALF  = BP_DIVIDE * OSC_H;
    logic        mclk, srst, proc_mode, req, slave_req, ext_bp, ext_bp_en;
    logic [3:0]  req_data;
    logic [1:0]  req_digit;
    logic        busy, slave_mode;
    logic [27:0] seg;
    int          num_errors  = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [6:0]  glyph_tab [16] = '{GLYPH_0, GLYPH_1, GLYPH_2, GLYPH_3,
        GLYPH_4, GLYPH_5, GLYPH_6, GLYPH_7, GLYPH_8, GLYPH_9, GLYPH_DASH,
        GLYPH_E, GLYPH_H, GLYPH_L, GLYPH_P, GLYPH_BLANK};

    lcdd_if link ();
    lcdd_driver #(.OSC_HALF(OSC_H), .BP_DIV(BP_DIVIDE), .IGNORE_CY(IGN))
        lcdd_driver_inst (.mclk(mclk), .srst(srst), .proc_mode(proc_mode),
        .link(link.dev), .seg(seg), .slave_mode(slave_mode));
    lcdd_source lcdd_source_inst (.mclk(mclk), .srst(srst),
        .proc_mode(proc_mode), .req(req), .req_data(req_data),
        .req_digit(req_digit), .slave_req(slave_req), .ext_bp(ext_bp),
        .ext_bp_en(ext_bp_en), .link(link.src), .busy(busy));
    lcdd_checker #(.HALF_CYC(HALF)) lcdd_checker_inst (.mclk(mclk),
        .srst(srst), .data_in(link.data_in),
        .digit_strobe_one(link.digit_strobe_one),
        .digit_addr_low(link.digit_addr_low),
        .digit_addr_high(link.digit_addr_high),
        .select_low_a(link.select_low_a), .select_low_b(link.select_low_b),
        .timebase_pin(link.timebase_pin), .bp_out(link.bp_out),
        .bp_oe(link.bp_oe));

    // ==========================================================
    // Clock, timeout and shared tasks
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [27:0] exp,
                         input logic [27:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic write(input logic [3:0] v, input logic [1:0] k);
        int         n;
        logic [1:0] addr;
        n = 0;
        addr = 2'h0;
        @(negedge mclk);
        req = 1'b1;
        req_data = v;
        req_digit = k;
        @(negedge mclk);
        req = 1'b0;
        do begin
            @(negedge mclk);
            n++;
            if (!link.select_low_a && !link.select_low_b)
                addr = {link.digit_addr_high, link.digit_addr_low};
        end while (busy !== 1'b0 && n < 300);
        if (proc_mode) check("address", {26'h0, ~k}, {26'h0, addr});
    endtask : write
    // Segments lag the pin by one cycle as master and two as slave,
    // so wait for three equal backplane samples before comparing
    task automatic chk_seg(input logic [1:0] k, input logic [6:0] g);
        logic b;
        int   s;
        b = link.bp_in;
        s = 0;
        while (s < 2) begin
            @(negedge mclk);
            if (link.bp_in === b) begin
                s++;
            end else begin
                b = link.bp_in;
                s = 0;
            end
        end
        check("seg", {21'h0, g ^ {7{b}}}, {21'h0, seg[7*k +: 7]});
    endtask : chk_seg
    task automatic wait_bp(output int n);
        logic b;
        b = link.bp_out;
        n = 0;
        while (link.bp_out === b && n < 1000) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_bp

    // ==========================================================
    // Scenarios
    task automatic t_bp();
        int n;
        wait_bp(n);
        wait_bp(n);
        check("bp half period", 28'(HALF), 28'(n));
    endtask : t_bp
    task automatic t_strobe();
        proc_mode = 1'b0;
        for (int v = 0; v < 16; v++) begin
            write(4'(v), 2'(v));
            chk_seg(2'(v), glyph_tab[v]);
        end
        chk_seg(2'h0, glyph_tab[12]);
    endtask : t_strobe
    task automatic t_glitch();
        slave_req = 1'b1;
        @(negedge mclk);
        slave_req = 1'b0;
        repeat (10) begin
            @(negedge mclk);
            check("slave mode", 28'h0, {27'h0, slave_mode});
        end
    endtask : t_glitch
    task automatic t_slave();
        ext_bp = 1'b1;
        ext_bp_en = 1'b1;
        slave_req = 1'b1;
        repeat (10) @(negedge mclk);
        check("slave mode", 28'h1, {27'h0, slave_mode});
        check("bp drive", 28'h0, {27'h0, link.bp_oe});
        chk_seg(2'h1, glyph_tab[13]);
        ext_bp = 1'b0;
        chk_seg(2'h1, glyph_tab[13]);
        slave_req = 1'b0;
        ext_bp_en = 1'b0;
        repeat (10) @(negedge mclk);
        check("bp drive", 28'h1, {27'h0, link.bp_oe});
    endtask : t_slave
    task automatic t_reset();
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        check("seg in reset", {4{SEG_RESET}}, seg);
        srst = 1'b0;
    endtask : t_reset
    task automatic t_proc();
        proc_mode = 1'b1;
        for (int k = 0; k < 4; k++) begin
            write(4'(k + 5), 2'(k));
            chk_seg(2'(k), glyph_tab[k + 5]);
        end
        chk_seg(2'h0, glyph_tab[5]);
    endtask : t_proc

    initial begin
        srst = 1'b1;
        proc_mode = 1'b0;
        req = 1'b0;
        req_data = 4'h0;
        req_digit = 2'h0;
        slave_req = 1'b0;
        ext_bp = 1'b0;
        ext_bp_en = 1'b0;
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        t_bp();
        t_strobe();
        t_glitch();
        t_slave();
        t_reset();
        t_proc();
        stop_test();
    end
endmodule : four_digit_segment_lcd_driver_tb
